/* File: rtl/rwp_ctrl.sv */
// run state, turn-on source, clear-faults and write-lock command logic
`timescale 1ns/1ns
`default_nettype none
`include "rwp_map.svh"

module rwp_ctrl
	import rwp_pkg::*;
(
	input wire logic core_clk,
	input wire logic rst_n,
	input wire rwp_cmd_t cmd_in,
	input wire logic enable_pin,
	input wire logic power_present,
	input wire logic fault_event,
	output rwp_seq_t seq_out,
	output logic [7:0] rd_data,
	output logic rd_valid,
	output logic ext_write_grant,
	output logic cml_error,
	output logic clear_faults_pulse,
	output logic alert_output_o,
	output logic alert_output_oe
);

	logic [7:0] run_state_control_reg;
	logic [7:0] turn_on_source_config_reg;
	logic [7:0] write_lock_level_reg;
	logic [1:0] pin_sync_reg;
	logic [1:0] pwr_sync_reg;
	logic alert_reg;
	rwp_off_cause_t off_cause_reg;
	rwp_off_cause_t off_cause_next;
	logic run_next;
	logic pin_active;
	logic op_req;
	logic pin_req;
	logic wr;
	logic wr_allowed;
	logic wr_valid_code;
	logic clr_req;

	// write permission for a command code under a lock level
	function automatic logic lock_permits(input logic [2:0] lvl,
		input logic [7:0] code);
		logic ok;
		ok = 1'b0;
		case (lvl)
			`RWP_LOCK_OPEN: ok = 1'b1;
			`RWP_LOCK_ALL: ok = (code == `RWP_CODE_WRITE_LOCK);
			`RWP_LOCK_OP: ok = (code == `RWP_CODE_WRITE_LOCK) ||
				(code == `RWP_CODE_RUN_STATE);
			`RWP_LOCK_CTRL: ok = (code == `RWP_CODE_WRITE_LOCK) ||
				(code == `RWP_CODE_RUN_STATE) ||
				(code == `RWP_CODE_ON_SOURCE) ||
				(code == `RWP_CODE_VOUT_CMD);
			// undefined lock codes are treated as fully locked, the safe side
			default: ok = (code == `RWP_CODE_WRITE_LOCK);
		endcase
		return ok;
	endfunction : lock_permits

	// run-state data carrying reserved margin or policy codes is refused
	function automatic logic run_state_ok(input logic [7:0] d);
		logic ok;
		ok = 1'b1;
		if (d[`RWP_OP_MARGIN_HI:`RWP_OP_MARGIN_LO] == 2'h3) begin
			ok = 1'b0;
		end
		if (d[`RWP_OP_MFLT_HI:`RWP_OP_MFLT_LO] != `RWP_MFLT_IGNORE &&
			d[`RWP_OP_MFLT_HI:`RWP_OP_MFLT_LO] != `RWP_MFLT_ACT) begin
			ok = 1'b0;
		end
		return ok;
	endfunction : run_state_ok

	assign wr = cmd_in.valid && cmd_in.write;
	assign wr_allowed = lock_permits(
		write_lock_level_reg[`RWP_LOCK_HI:`RWP_LOCK_LO], cmd_in.code);
	assign wr_valid_code = (cmd_in.code != `RWP_CODE_RUN_STATE) ||
		run_state_ok(cmd_in.data);
	// clear-faults is a send-byte; the lock still applies to it
	assign clr_req = wr && cmd_in.code == `RWP_CODE_CLEAR_FLT && wr_allowed;

	// pin and power status come from outside the clock domain
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			pin_sync_reg <= 2'b00;
			pwr_sync_reg <= 2'b00;
		end else begin
			pin_sync_reg <= {pin_sync_reg[0], enable_pin};
			pwr_sync_reg <= {pwr_sync_reg[0], power_present};
		end
	end

	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			run_state_control_reg <= `RWP_RUN_STATE_RST;
		end else if (wr && cmd_in.code == `RWP_CODE_RUN_STATE &&
			wr_allowed && wr_valid_code) begin
			run_state_control_reg <= cmd_in.data;
		end
	end

	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			turn_on_source_config_reg <= `RWP_ON_SOURCE_RST;
		end else if (wr && cmd_in.code == `RWP_CODE_ON_SOURCE &&
			wr_allowed) begin
			turn_on_source_config_reg <= cmd_in.data & `RWP_CFG_USED_MASK;
		end
	end

	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			write_lock_level_reg <= `RWP_WRITE_LOCK_RST;
		end else if (wr && cmd_in.code == `RWP_CODE_WRITE_LOCK) begin
			write_lock_level_reg <= cmd_in.data & `RWP_LOCK_USED_MASK;
		end
	end

	// polarity bit 1 means active high
	assign pin_active = turn_on_source_config_reg[`RWP_CFG_POL_BIT] ?
		pin_sync_reg[1] : ~pin_sync_reg[1];
	assign op_req = !turn_on_source_config_reg[`RWP_CFG_CMD_BIT] ||
		run_state_control_reg[`RWP_OP_ON_BIT];
	assign pin_req = !turn_on_source_config_reg[`RWP_CFG_PIN_BIT] ||
		pin_active;

	always_comb begin
		if (!turn_on_source_config_reg[`RWP_CFG_PU_BIT]) begin
			run_next = pwr_sync_reg[1];
		end else begin
			run_next = pwr_sync_reg[1] && op_req && pin_req;
		end
	end

	// remember what dropped the run request, to pick the off style
	always_comb begin
		off_cause_next = off_cause_reg;
		if (run_next) begin
			off_cause_next = RWP_OFF_NONE;
		end else if (seq_out.run) begin
			// power loss, or any drop while the power-up gate is off,
			// takes the pin-style off timing
			off_cause_next = (op_req || !pwr_sync_reg[1] ||
				!turn_on_source_config_reg[`RWP_CFG_PU_BIT]) ?
				RWP_OFF_PIN : RWP_OFF_CMD;
		end
	end

	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			off_cause_reg <= RWP_OFF_NONE;
		end else begin
			off_cause_reg <= off_cause_next;
		end
	end

	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			seq_out <= '0;
		end else begin
			seq_out.run <= run_next;
			case (off_cause_next)
				RWP_OFF_CMD: seq_out.instant_off <=
					!run_state_control_reg[`RWP_OP_SEQ_OFF_BIT];
				RWP_OFF_PIN: seq_out.instant_off <=
					turn_on_source_config_reg[`RWP_CFG_INST_BIT];
				RWP_OFF_NONE: seq_out.instant_off <= 1'b0;
				default: seq_out.instant_off <= 1'b0;
			endcase
			seq_out.vout_select <=
				run_state_control_reg[`RWP_OP_MARGIN_HI:`RWP_OP_MARGIN_LO];
			seq_out.margin_fault_ignore <=
				run_state_control_reg[`RWP_OP_MFLT_HI:`RWP_OP_MFLT_LO] ==
				`RWP_MFLT_IGNORE;
		end
	end

	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			clear_faults_pulse <= 1'b0;
		end else begin
			clear_faults_pulse <= clr_req;
		end
	end

	// a fault in the clearing cycle keeps alert asserted
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			alert_reg <= 1'b0;
		end else if (fault_event) begin
			alert_reg <= 1'b1;
		end else if (clr_req) begin
			alert_reg <= 1'b0;
		end
	end

	// open-drain: drive low while asserted, so the value is always 0
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			alert_output_o <= 1'b0;
			alert_output_oe <= 1'b0;
		end else begin
			alert_output_o <= 1'b0;
			alert_output_oe <= alert_reg;
		end
	end

	// other commands are written elsewhere; this only grants them
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			ext_write_grant <= 1'b0;
			cml_error <= 1'b0;
		end else begin
			ext_write_grant <= wr && wr_allowed &&
				cmd_in.code != `RWP_CODE_RUN_STATE &&
				cmd_in.code != `RWP_CODE_ON_SOURCE &&
				cmd_in.code != `RWP_CODE_WRITE_LOCK &&
				cmd_in.code != `RWP_CODE_CLEAR_FLT;
			cml_error <= wr && !(wr_allowed && wr_valid_code);
		end
	end

	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			rd_data <= 8'h00;
			rd_valid <= 1'b0;
		end else begin
			rd_valid <= cmd_in.valid && !cmd_in.write;
			case (cmd_in.code)
				`RWP_CODE_RUN_STATE: rd_data <= run_state_control_reg;
				`RWP_CODE_ON_SOURCE: rd_data <= turn_on_source_config_reg;
				`RWP_CODE_WRITE_LOCK: rd_data <= write_lock_level_reg;
				default: rd_data <= 8'h00;
			endcase
		end
	end

endmodule : rwp_ctrl
`default_nettype wire

/* File: rtl/rwp_map.svh */
// command codes, field positions, reset values of the run-control block
`ifndef RWP_MAP_SVH
`define RWP_MAP_SVH

`define RWP_CODE_RUN_STATE 8'h01
`define RWP_CODE_ON_SOURCE 8'h02
`define RWP_CODE_CLEAR_FLT 8'h03
`define RWP_CODE_WRITE_LOCK 8'h10
`define RWP_CODE_VOUT_CMD 8'h21

`define RWP_RUN_STATE_RST 8'h88
`define RWP_ON_SOURCE_RST 8'h1f
`define RWP_WRITE_LOCK_RST 8'h00

`define RWP_OP_ON_BIT 7
`define RWP_OP_SEQ_OFF_BIT 6
`define RWP_OP_MARGIN_HI 5
`define RWP_OP_MARGIN_LO 4
`define RWP_OP_MFLT_HI 3
`define RWP_OP_MFLT_LO 2

`define RWP_CFG_PU_BIT 4
`define RWP_CFG_CMD_BIT 3
`define RWP_CFG_PIN_BIT 2
`define RWP_CFG_POL_BIT 1
`define RWP_CFG_INST_BIT 0
`define RWP_CFG_USED_MASK 8'h1f

`define RWP_LOCK_HI 7
`define RWP_LOCK_LO 5
`define RWP_LOCK_USED_MASK 8'he0
`define RWP_LOCK_OPEN 3'h0
`define RWP_LOCK_ALL 3'h4
`define RWP_LOCK_OP 3'h2
`define RWP_LOCK_CTRL 3'h1

`define RWP_MARGIN_NOM 2'h0
`define RWP_MARGIN_LOW 2'h1
`define RWP_MARGIN_HIGH 2'h2
`define RWP_MFLT_IGNORE 2'h1
`define RWP_MFLT_ACT 2'h2

`endif

/* File: rtl/rwp_pkg.sv */
// types shared by the run-control and write-lock block
package rwp_pkg;

	// one decoded command from the bus front end
	typedef struct packed {
		logic valid;
		logic write;
		logic [7:0] code;
		logic [7:0] data;
	} rwp_cmd_t;

	// settings handed to the power-stage sequencer
	typedef struct packed {
		logic run;
		logic instant_off;
		logic [1:0] vout_select;
		logic margin_fault_ignore;
	} rwp_seq_t;

	typedef enum logic [1:0] {
		RWP_OFF_NONE,
		RWP_OFF_CMD,
		RWP_OFF_PIN
	} rwp_off_cause_t;

endpackage : rwp_pkg

/* File: sim/rwp_ctrl_checker.sv */
// port assertions for the run-control block
`timescale 1ns/1ns
`default_nettype none
module rwp_ctrl_checker
	import rwp_pkg::*;
(
	input wire logic core_clk,
	input wire logic rst_n,
	input wire rwp_cmd_t cmd_in,
	input wire logic power_present,
	input wire logic fault_event,
	input wire rwp_seq_t seq_out,
	input wire logic rd_valid,
	input wire logic ext_write_grant,
	input wire logic cml_error,
	input wire logic clear_faults_pulse,
	input wire logic alert_output_o,
	input wire logic alert_output_oe
);
	default clocking @(posedge core_clk); endclocking
	default disable iff (!rst_n);
	logic wr;
	logic rn;
	assign wr = cmd_in.valid && cmd_in.write;
	assign rn = wr && cmd_in.code == 8'h01;
	property p_read; cmd_in.valid && !cmd_in.write |=> rd_valid; endproperty
	a_read: assert property (p_read) else $error("read unanswered");
	property p_one;
		$onehot0({rd_valid, ext_write_grant, cml_error, clear_faults_pulse});
	endproperty
	a_one: assert property (p_one) else $error("two answers");
	property p_margin; rn && cmd_in.data[5:4] == 2'h3 |=> cml_error; endproperty
	a_margin: assert property (p_margin) else $error("bad margin kept");
	property p_mflt;
		rn && cmd_in.data[3:2] inside {2'h0, 2'h3} |=> cml_error;
	endproperty
	a_mflt: assert property (p_mflt) else $error("bad policy kept");
	property p_sel;
		rn ##1 !cml_error |=> seq_out.vout_select == $past(cmd_in.data[5:4], 2);
	endproperty
	a_sel: assert property (p_sel) else $error("target not applied");
	property p_aset; fault_event |-> ##2 alert_output_oe; endproperty
	a_aset: assert property (p_aset) else $error("alert not raised");
	property p_aclr;
		clear_faults_pulse && !fault_event && !$past(fault_event)
			|=> !alert_output_oe;
	endproperty
	a_aclr: assert property (p_aclr) else $error("alert held");
	property p_pwr; !power_present |-> ##3 !seq_out.run; endproperty
	a_pwr: assert property (p_pwr) else $error("runs unpowered");
	property p_od; alert_output_o == 1'b0; endproperty
	a_od: assert property (p_od) else $error("alert drives high");
	c_run: cover property ($rose(seq_out.run));
	c_err: cover property (cml_error);
	c_clr: cover property (clear_faults_pulse && alert_output_oe);
endmodule : rwp_ctrl_checker
bind rwp_ctrl rwp_ctrl_checker chk (.core_clk, .rst_n, .cmd_in,
	.power_present, .fault_event, .seq_out, .rd_valid, .ext_write_grant,
	.cml_error, .clear_faults_pulse, .alert_output_o, .alert_output_oe);
`default_nettype wire

/* File: sim/rwp_ctrl_tb.sv */
// self-checking bench for the run-control and write-lock block
`timescale 1ns/1ns
`default_nettype none
module rwp_ctrl_tb
	import rwp_pkg::*;
;
	logic core_clk = 1'b0, rst_n = 1'b0, power_present = 1'b1;
	logic fault_event = 1'b0, want_on = 1'b1, act_hi = 1'b1, enable_pin;
	rwp_cmd_t cmd_in = '0;
	rwp_seq_t seq_out;
	logic [7:0] rd_data, rv, cur = 8'h88;
	logic rd_valid, grant, err, clr, al_o, al_oe, bad, ok;
	logic [3:0] fl, ex;
	logic [7:0] mt [5] = '{8'h98, 8'ha4, 8'hb8, 8'h80, 8'h8c};
	logic [7:0] lk [4] = '{8'h00, 8'h80, 8'h40, 8'h20};
	logic [7:0] cd [4] = '{8'h01, 8'h02, 8'h21, 8'h03};
	logic [7:0] dv [4] = '{8'ha4, 8'h1f, 8'h00, 8'h00};
	logic [3:0] okm [4] = '{4'hf, 4'h0, 4'h1, 4'h7};
	int fails = 0, comparisons = 0;
	rwp_pin_drv drv (.want_on(want_on), .active_high(act_hi),
		.enable_pin(enable_pin));
	rwp_ctrl uut (.core_clk(core_clk), .rst_n(rst_n), .cmd_in(cmd_in),
		.enable_pin(enable_pin), .power_present(power_present),
		.fault_event(fault_event), .seq_out(seq_out), .rd_data(rd_data),
		.rd_valid(rd_valid), .ext_write_grant(grant), .cml_error(err),
		.clear_faults_pulse(clr), .alert_output_o(al_o),
		.alert_output_oe(al_oe));
	initial forever #4 core_clk = ~core_clk;
	task automatic chk(input string n, input logic [7:0] e, g);
		comparisons++;
		if (g !== e) begin
			fails++;
			$display("Error %s expected %h seen %h", n, e, g);
		end
	endtask : chk
	task automatic op(input logic w, input logic [7:0] c, d);
		@(posedge core_clk);
		cmd_in <= '{1'b1, w, c, d};
		@(posedge core_clk);
		cmd_in <= '0;
		// answers stand for one cycle only, so look straight after the edge
		@(negedge core_clk);
		fl = {rd_valid, grant, err, clr};
		rv = rd_data;
	endtask : op
	task automatic wt(input int n);
		repeat (n) @(posedge core_clk);
		@(negedge core_clk);
	endtask : wt
	task automatic rd(input logic [7:0] c, e);
		op(1'b0, c, 8'h00);
		chk("read data", e, rv);
		chk("read flags", 8'h08, {4'h0, fl});
	endtask : rd
	// waits out the two pin sync stages and the run register
	task automatic run_is(input logic e);
		wt(4);
		chk("run", {7'h0, e}, {7'h0, seq_out.run});
	endtask : run_is
	task automatic set_pin(input logic w, h);
		@(posedge core_clk);
		want_on <= w;
		act_hi <= h;
	endtask : set_pin
	task automatic wrap_up;
		$display("comparisons %0d fails %0d", comparisons, fails);
		if (fails == 0 && comparisons > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask : wrap_up
	initial begin
		#400000;
		fails++;
		wrap_up();
	end
	initial begin
		repeat (12) @(posedge core_clk);
		rst_n <= 1'b1;
		rd(8'h01, 8'h88);
		rd(8'h02, 8'h1f);
		rd(8'h10, 8'h00);
		run_is(1'b1);
		set_pin(1'b0, 1'b1);
		run_is(1'b0);
		chk("instant off", 8'h01, {7'h0, seq_out.instant_off});
		op(1'b1, 8'h02, 8'h1d);
		set_pin(1'b1, 1'b0);
		run_is(1'b1);
		set_pin(1'b0, 1'b0);
		run_is(1'b0);
		set_pin(1'b1, 1'b0);
		run_is(1'b1);
		op(1'b1, 8'h01, 8'h08);
		run_is(1'b0);
		chk("instant off", 8'h01, {7'h0, seq_out.instant_off});
		op(1'b1, 8'h01, 8'h88);
		run_is(1'b1);
		op(1'b1, 8'h01, 8'h48);
		run_is(1'b0);
		chk("instant off", 8'h00, {7'h0, seq_out.instant_off});
		op(1'b1, 8'h02, 8'h15);
		run_is(1'b1);
		op(1'b1, 8'h02, 8'h19);
		op(1'b1, 8'h01, 8'h88);
		set_pin(1'b0, 1'b0);
		run_is(1'b1);
		op(1'b1, 8'h02, 8'h09);
		op(1'b1, 8'h01, 8'h08);
		run_is(1'b1);
		@(posedge core_clk);
		power_present <= 1'b0;
		run_is(1'b0);
		@(posedge core_clk);
		power_present <= 1'b1;
		op(1'b1, 8'h02, 8'h1f);
		set_pin(1'b1, 1'b1);
		$display("on off test done");
		foreach (mt[i]) begin
			op(1'b1, 8'h01, mt[i]);
			bad = mt[i][5:4] == 2'h3 || mt[i][3:2] inside {2'h0, 2'h3};
			chk("margin error", {7'h0, bad}, {7'h0, fl[1]});
			cur = bad ? cur : mt[i];
			rd(8'h01, cur);
			chk("target", {6'h0, cur[5:4]}, {6'h0, seq_out.vout_select});
			chk("ignore", {7'h0, cur[3:2] == 2'h1},
				{7'h0, seq_out.margin_fault_ignore});
		end
		$display("margin test done");
		@(posedge core_clk);
		fault_event <= 1'b1;
		@(posedge core_clk);
		fault_event <= 1'b0;
		wt(3);
		chk("alert", 8'h01, {7'h0, al_oe});
		op(1'b1, 8'h03, 8'h00);
		chk("clear flags", 8'h01, {4'h0, fl});
		wt(1);
		chk("alert", 8'h00, {7'h0, al_oe});
		$display("clear test done");
		foreach (lk[i]) begin
			op(1'b1, 8'h10, lk[i]);
			chk("lock flags", 8'h00, {4'h0, fl});
			foreach (cd[j]) begin
				op(1'b1, cd[j], dv[j]);
				ok = okm[i][j];
				ex = {1'b0, ok && j == 2, !ok, ok && j == 3};
				chk("gate", {4'h0, ex}, {4'h0, fl});
			end
		end
		op(1'b1, 8'h10, 8'hff);
		rd(8'h10, 8'he0);
		op(1'b1, 8'h02, 8'h0f);
		rd(8'h02, 8'h1f);
		$display("lock test done");
		wrap_up();
	end
endmodule : rwp_ctrl_tb
`default_nettype wire

/* File: sim/rwp_pin_drv.sv */
// enable pin driver standing in for the board control line
`timescale 1ns/1ns
`default_nettype none
module rwp_pin_drv (
	input wire logic want_on,
	input wire logic active_high,
	output logic enable_pin
);
	// level that asks for on at the chosen polarity
	assign enable_pin = want_on ~^ active_high;
endmodule : rwp_pin_drv
`default_nettype wire
